// *** rtl/nmpe_map.svh ***
`ifndef NMPE_MAP_SVH
`define NMPE_MAP_SVH
// clock and pin timing
`define NMPE_CLK_NS 10
`define NMPE_WE_LOW_NS 20
`define NMPE_WE_LOW_CYC ((`NMPE_WE_LOW_NS + `NMPE_CLK_NS - 1) / `NMPE_CLK_NS)
`define NMPE_WE_HIGH_NS 20
`define NMPE_WE_HIGH_CYC ((`NMPE_WE_HIGH_NS + `NMPE_CLK_NS - 1) / `NMPE_CLK_NS)
`define NMPE_RE_LOW_NS 40
`define NMPE_RE_LOW_CYC ((`NMPE_RE_LOW_NS + `NMPE_CLK_NS - 1) / `NMPE_CLK_NS)
`define NMPE_BUSY_START_NS 100
`define NMPE_BUSY_START_CYC \
   ((`NMPE_BUSY_START_NS + `NMPE_CLK_NS - 1) / `NMPE_CLK_NS)
// command bytes
`define NMPE_CMD_READ_SETUP 8'h00
`define NMPE_CMD_READ_COPY 8'h35
`define NMPE_CMD_SERIAL_IN 8'h80
`define NMPE_CMD_SECOND_PAGE 8'h81
`define NMPE_CMD_COL_CHANGE 8'h85
`define NMPE_CMD_PROG_CONFIRM 8'h10
`define NMPE_CMD_PAGE_END 8'h11
`define NMPE_CMD_ERASE_SETUP 8'h60
`define NMPE_CMD_ERASE_START 8'hd0
`define NMPE_CMD_STATUS 8'h70
`define NMPE_CMD_DIST_STATUS 8'h71
`define NMPE_CMD_RESET 8'hff
// geometry and limits
`define NMPE_SECTOR_BYTES 12'd528
`define NMPE_PAGE_BYTES 12'd2112
`define NMPE_MAX_PROGS 3'h4
// address selectors of an address element
`define NMPE_ASEL_FULL1 8'h00
`define NMPE_ASEL_FULL2 8'h01
`define NMPE_ASEL_ROW1 8'h02
`define NMPE_ASEL_ROW2 8'h03
`define NMPE_ADDR_LAST 3'h4
// status bit positions
`define NMPE_ST_FAIL 0
`define NMPE_ST_D0_FAIL 1
`define NMPE_ST_D1_FAIL 2
`define NMPE_ST_READY 6
`define NMPE_ST_WP_N 7
`endif

// *** rtl/nmpe_pkg.sv ***
package nmpe_pkg;
   // user operations
   typedef enum logic [2:0] {
      OP_PROG = 3'h0,
      OP_MPROG = 3'h1,
      OP_ERASE = 3'h2,
      OP_MERASE = 3'h3,
      OP_COPY = 3'h4,
      OP_STATUS = 3'h5,
      OP_DSTATUS = 3'h6,
      OP_RESET = 3'h7
   } nmpe_op_t;
   // kinds of sequence element
   typedef enum logic [2:0] {
      EK_CMD = 3'h0,
      EK_ADDR = 3'h1,
      EK_DATA = 3'h2,
      EK_WAIT = 3'h3,
      EK_READ = 3'h4,
      EK_END = 3'h5
   } nmpe_kind_t;
   typedef enum logic {
      ST_IDLE = 1'b0,
      ST_RUN = 1'b1
   } nmpe_state_t;
   typedef struct packed {
      nmpe_kind_t kind;
      logic [7:0] val;
   } nmpe_elem_t;
endpackage : nmpe_pkg

// *** rtl/nmpe_fifo.sv ***
module nmpe_fifo #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 16
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic en,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int unsigned AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] rd_r, wr_r;
   logic [AW:0] cnt_r, cnt_nxt;
   logic push, pop;

   // handshakes on both sides
   assign push = in_valid && in_ready && en;
   assign pop = out_valid && out_ready && en;
   assign out_valid = cnt_r != '0;
   assign out_data = mem[rd_r];

   // fill level
   always_comb begin
      cnt_nxt = cnt_r;
      if (push && !pop) cnt_nxt = cnt_r + 1'b1;
      else if (pop && !push) cnt_nxt = cnt_r - 1'b1;
   end

   // pointers, level and registered ready
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rd_r <= '0;
         wr_r <= '0;
         cnt_r <= '0;
         in_ready <= 1'b1;
      end else if (en) begin
         if (push) wr_r <= wr_r + 1'b1;
         if (pop) rd_r <= rd_r + 1'b1;
         cnt_r <= cnt_nxt;
         in_ready <= cnt_nxt != FULL;
      end
   end

   // storage
   always_ff @(posedge clk) begin
      if (push) mem[wr_r] <= in_data;
   end
endmodule : nmpe_fifo

// *** rtl/nmpe_host.sv ***
`include "nmpe_map.svh"
// Notes on behaviour
// - multi ops: one block per district, shared page
// - write protect stays high during operations
// - program whole sectors, four per page; any length from 528 to 2112 bytes is taken
// - serial input, address, data, then confirm
// - second page only after page-end, ready
// - multi program ends only with confirm
// - two setup groups, one start, district status
// - abandon unfinished sequence with reset command
// - copy: data input, destination, optional data, confirm
// - copy source and destination share a district
// - command and address latch levels per cycle
// - five address bytes, block above page bits
module nmpe_host (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic en,
   input wire logic cmd_valid,
   output logic cmd_ready,
   input nmpe_pkg::nmpe_op_t cmd_op,
   input wire logic [10:0] cmd_block1,
   input wire logic [10:0] cmd_block2,
   input wire logic [5:0] cmd_page,
   input wire logic [11:0] cmd_col,
   input wire logic [11:0] cmd_len,
   input wire logic abort,
   input wire logic wp_req,
   input wire logic wr_valid,
   output logic wr_ready,
   input wire logic [7:0] wr_data,
   output logic done_r,
   output logic err_r,
   output logic busy_r,
   output logic [7:0] status_r,
   output logic nand_ce_n_r,
   output logic nand_cle_r,
   output logic nand_ale_r,
   output logic nand_we_n_r,
   output logic nand_re_n_r,
   output logic nand_wp_n_r,
   output logic [7:0] nand_io_o_r,
   output logic nand_io_oe_r,
   input wire logic [7:0] nand_io_i,
   input wire logic ready_busy_n
);
   localparam logic [7:0] WE_LO = 8'(`NMPE_WE_LOW_CYC);
   localparam logic [7:0] BYTE_END = 8'(`NMPE_WE_LOW_CYC + `NMPE_WE_HIGH_CYC);
   localparam logic [7:0] RE_LO = 8'(`NMPE_RE_LOW_CYC);
   localparam logic [7:0] RE_END = 8'(`NMPE_RE_LOW_CYC + `NMPE_WE_HIGH_CYC);
   localparam logic [7:0] WB = 8'(`NMPE_BUSY_START_CYC);

   nmpe_pkg::nmpe_state_t state_r;
   nmpe_pkg::nmpe_op_t op_r;
   nmpe_pkg::nmpe_elem_t elem;
   logic [3:0] step_r;
   logic [7:0] cnt_r;
   logic [2:0] bidx_r, bsel, nprog_r;
   logic [11:0] dcnt_r, len_r, col_r;
   logic [10:0] blk1_r, blk2_r;
   logic [5:0] page_r;
   logic [16:0] last_pg_r, key;
   logic [7:0] io_s1_r, io_s2_r, abyte, fifo_data;
   logic rb_s1_r, rb_s2_r, fifo_v, fifo_pop, run, drive;
   logic take, refused, is_prog, is_multi, adv, byte_end, abort_go;

   function automatic nmpe_pkg::nmpe_elem_t mk(
      input nmpe_pkg::nmpe_kind_t k, input logic [7:0] v);
      return '{kind: k, val: v};
   endfunction : mk

   function automatic nmpe_pkg::nmpe_elem_t c(input logic [7:0] v);
      return mk(nmpe_pkg::EK_CMD, v);
   endfunction : c

   // sequence of pin cycles per operation
   function automatic nmpe_pkg::nmpe_elem_t script(
      input nmpe_pkg::nmpe_op_t op, input logic [3:0] st);
      nmpe_pkg::nmpe_elem_t e, a1, a2, r1, r2, d, w, rd, x;
      a1 = mk(nmpe_pkg::EK_ADDR, `NMPE_ASEL_FULL1);
      a2 = mk(nmpe_pkg::EK_ADDR, `NMPE_ASEL_FULL2);
      r1 = mk(nmpe_pkg::EK_ADDR, `NMPE_ASEL_ROW1);
      r2 = mk(nmpe_pkg::EK_ADDR, `NMPE_ASEL_ROW2);
      d = mk(nmpe_pkg::EK_DATA, 8'h00);
      w = mk(nmpe_pkg::EK_WAIT, 8'h00);
      rd = mk(nmpe_pkg::EK_READ, 8'h00);
      x = mk(nmpe_pkg::EK_END, 8'h00);
      e = x;
      case (op)
         nmpe_pkg::OP_PROG: begin
            case (st)
               4'h0: e = c(`NMPE_CMD_SERIAL_IN);
               4'h1: e = a1;
               4'h2: e = d;
               4'h3: e = c(`NMPE_CMD_PROG_CONFIRM);
               4'h4: e = w;
               4'h5: e = c(`NMPE_CMD_STATUS);
               4'h6: e = rd;
               default: e = x;
            endcase
         end
         nmpe_pkg::OP_MPROG: begin
            case (st)
               4'h0: e = c(`NMPE_CMD_SERIAL_IN);
               4'h1: e = a1;
               4'h2: e = d;
               4'h3: e = c(`NMPE_CMD_PAGE_END);
               4'h4: e = w;
               4'h5: e = c(`NMPE_CMD_SECOND_PAGE);
               4'h6: e = a2;
               4'h7: e = d;
               4'h8: e = c(`NMPE_CMD_PROG_CONFIRM);
               4'h9: e = w;
               4'ha: e = c(`NMPE_CMD_DIST_STATUS);
               4'hb: e = rd;
               default: e = x;
            endcase
         end
         nmpe_pkg::OP_ERASE, nmpe_pkg::OP_MERASE: begin
            case (st)
               4'h0: e = c(`NMPE_CMD_ERASE_SETUP);
               4'h1: e = r1;
               4'h2: e = (op == nmpe_pkg::OP_MERASE) ?
                         c(`NMPE_CMD_ERASE_SETUP) : c(`NMPE_CMD_ERASE_START);
               4'h3: e = (op == nmpe_pkg::OP_MERASE) ? r2 : w;
               4'h4: e = (op == nmpe_pkg::OP_MERASE) ?
                         c(`NMPE_CMD_ERASE_START) : c(`NMPE_CMD_STATUS);
               4'h5: e = (op == nmpe_pkg::OP_MERASE) ? w : rd;
               4'h6: e = (op == nmpe_pkg::OP_MERASE) ?
                         c(`NMPE_CMD_DIST_STATUS) : x;
               4'h7: e = (op == nmpe_pkg::OP_MERASE) ? rd : x;
               default: e = x;
            endcase
         end
         nmpe_pkg::OP_COPY: begin
            case (st)
               4'h0: e = c(`NMPE_CMD_READ_SETUP);
               4'h1: e = a1;
               4'h2: e = c(`NMPE_CMD_READ_COPY);
               4'h3: e = w;
               4'h4: e = c(`NMPE_CMD_COL_CHANGE);
               4'h5: e = a2;
               4'h6: e = d;
               4'h7: e = c(`NMPE_CMD_PROG_CONFIRM);
               4'h8: e = w;
               4'h9: e = c(`NMPE_CMD_STATUS);
               4'ha: e = rd;
               default: e = x;
            endcase
         end
         nmpe_pkg::OP_STATUS, nmpe_pkg::OP_DSTATUS: begin
            case (st)
               4'h0: e = c((op == nmpe_pkg::OP_STATUS) ?
                         `NMPE_CMD_STATUS : `NMPE_CMD_DIST_STATUS);
               4'h1: e = rd;
               default: e = x;
            endcase
         end
         default: begin
            case (st)
               4'h0: e = c(`NMPE_CMD_RESET);
               4'h1: e = w;
               default: e = x;
            endcase
         end
      endcase
      return e;
   endfunction : script

   // address byte by index: two column, three row bytes
   function automatic logic [7:0] addr_byte(input logic [2:0] idx,
      input logic [11:0] col, input logic [16:0] row);
      case (idx)
         3'h0: addr_byte = col[7:0];
         3'h1: addr_byte = {4'h0, col[11:8]};
         3'h2: addr_byte = row[7:0];
         3'h3: addr_byte = row[15:8];
         default: addr_byte = {7'h00, row[16]};
      endcase
   endfunction : addr_byte

   nmpe_fifo #(.WIDTH(8), .DEPTH(16)) u_fifo (
      .clk(clk),
      .rst_b(rst_b),
      .en(en),
      .in_valid(wr_valid),
      .in_ready(wr_ready),
      .in_data(wr_data),
      .out_valid(fifo_v),
      .out_ready(fifo_pop),
      .out_data(fifo_data)
   );

   // request checks and element decode
   assign elem = script(op_r, step_r);
   assign run = state_r == nmpe_pkg::ST_RUN;
   assign take = cmd_valid && cmd_ready && state_r == nmpe_pkg::ST_IDLE;
   assign is_prog = cmd_op == nmpe_pkg::OP_PROG ||
                    cmd_op == nmpe_pkg::OP_MPROG;
   assign is_multi = cmd_op == nmpe_pkg::OP_MPROG ||
                     cmd_op == nmpe_pkg::OP_MERASE;
   assign key = (cmd_op == nmpe_pkg::OP_COPY) ? {cmd_block2, cmd_page} :
                {cmd_block1, cmd_page};
   assign refused = (is_multi && cmd_block1[0] == cmd_block2[0]) ||
      (cmd_op == nmpe_pkg::OP_COPY &&
       cmd_block1[0] != cmd_block2[0]) ||
      (is_prog && (cmd_len < `NMPE_SECTOR_BYTES ||
                   cmd_len > `NMPE_PAGE_BYTES)) ||
      ((is_prog || cmd_op == nmpe_pkg::OP_COPY) && key == last_pg_r &&
       nprog_r == `NMPE_MAX_PROGS);
   assign bsel = bidx_r + {elem.val[1], 1'b0};
   assign abyte = addr_byte(bsel, col_r,
      elem.val[0] ? {blk2_r, page_r} : {blk1_r, page_r});
   assign byte_end = cnt_r == BYTE_END;
   assign drive = elem.kind == nmpe_pkg::EK_CMD ||
      elem.kind == nmpe_pkg::EK_ADDR || elem.kind == nmpe_pkg::EK_DATA;
   assign fifo_pop = run && elem.kind == nmpe_pkg::EK_DATA && byte_end &&
                     dcnt_r != 12'h000;
   // abort only at an element start, between data bytes or in a wait, never inside an address
   assign abort_go = abort && run && op_r != nmpe_pkg::OP_RESET &&
      elem.kind != nmpe_pkg::EK_END &&
      ((cnt_r == 8'h00 && bidx_r == 3'h0) ||
       elem.kind == nmpe_pkg::EK_WAIT);

   // element completion
   always_comb begin
      case (elem.kind)
         nmpe_pkg::EK_CMD: adv = byte_end;
         nmpe_pkg::EK_ADDR: adv = byte_end && bsel == `NMPE_ADDR_LAST;
         nmpe_pkg::EK_DATA: adv = dcnt_r == 12'h000 ||
                                  (byte_end && dcnt_r == 12'h001);
         nmpe_pkg::EK_WAIT: adv = cnt_r == WB && rb_s2_r;
         nmpe_pkg::EK_READ: adv = cnt_r == RE_END;
         default: adv = 1'b0;
      endcase
   end

   // pin synchronisers
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         io_s1_r <= 8'h00;
         io_s2_r <= 8'h00;
         rb_s1_r <= 1'b0;
         rb_s2_r <= 1'b0;
      end else if (en) begin
         io_s1_r <= nand_io_i;
         io_s2_r <= io_s1_r;
         rb_s1_r <= ready_busy_n;
         rb_s2_r <= rb_s1_r;
      end
   end

   // sequencer
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_r <= nmpe_pkg::ST_IDLE;
         op_r <= nmpe_pkg::OP_STATUS;
         step_r <= 4'h0;
         cnt_r <= 8'h00;
         bidx_r <= 3'h0;
         dcnt_r <= 12'h000;
         len_r <= 12'h000;
         col_r <= 12'h000;
         blk1_r <= 11'h000;
         blk2_r <= 11'h000;
         page_r <= 6'h00;
      end else if (en) begin
         case (state_r)
            nmpe_pkg::ST_IDLE: begin
               step_r <= 4'h0;
               cnt_r <= 8'h00;
               bidx_r <= 3'h0;
               if (take && !refused) begin
                  state_r <= nmpe_pkg::ST_RUN;
                  op_r <= cmd_op;
                  blk1_r <= cmd_block1;
                  blk2_r <= cmd_block2;
                  page_r <= cmd_page;
                  col_r <= cmd_col;
                  len_r <= cmd_len;
                  dcnt_r <= cmd_len;
               end
            end
            default: begin
               if (abort_go) begin
                  op_r <= nmpe_pkg::OP_RESET;
                  step_r <= 4'h0;
                  cnt_r <= 8'h00;
                  bidx_r <= 3'h0;
               end else if (adv) begin
                  step_r <= step_r + 4'h1;
                  cnt_r <= 8'h00;
                  bidx_r <= 3'h0;
                  dcnt_r <= len_r;
               end else if (elem.kind == nmpe_pkg::EK_END) begin
                  state_r <= nmpe_pkg::ST_IDLE;
               end else if (elem.kind == nmpe_pkg::EK_ADDR && byte_end) begin
                  bidx_r <= bidx_r + 3'h1;
                  cnt_r <= 8'h00;
               end else if (elem.kind == nmpe_pkg::EK_DATA && byte_end) begin
                  dcnt_r <= dcnt_r - 12'h001;
                  cnt_r <= 8'h00;
               end else if (elem.kind == nmpe_pkg::EK_DATA) begin
                  if (cnt_r != 8'h00 || fifo_v) cnt_r <= cnt_r + 8'h01;
               end else if (elem.kind == nmpe_pkg::EK_WAIT) begin
                  if (cnt_r != WB) cnt_r <= cnt_r + 8'h01;
               end else begin
                  cnt_r <= cnt_r + 8'h01;
               end
            end
         endcase
      end
   end

   // device pins
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         nand_ce_n_r <= 1'b1;
         nand_cle_r <= 1'b0;
         nand_ale_r <= 1'b0;
         nand_we_n_r <= 1'b1;
         nand_re_n_r <= 1'b1;
         nand_wp_n_r <= 1'b1;
         nand_io_o_r <= 8'h00;
         nand_io_oe_r <= 1'b0;
      end else if (en) begin
         nand_ce_n_r <= !run;
         nand_cle_r <= run && elem.kind == nmpe_pkg::EK_CMD;
         nand_ale_r <= run && elem.kind == nmpe_pkg::EK_ADDR;
         nand_we_n_r <= !(run && drive && cnt_r >= 8'h01 && cnt_r <= WE_LO);
         nand_re_n_r <= !(run && elem.kind == nmpe_pkg::EK_READ &&
                          cnt_r >= 8'h01 && cnt_r <= RE_LO);
         nand_wp_n_r <= !(wp_req && !run);
         nand_io_oe_r <= run && drive;
         if (elem.kind == nmpe_pkg::EK_CMD) nand_io_o_r <= elem.val;
         else if (elem.kind == nmpe_pkg::EK_ADDR) nand_io_o_r <= abyte;
         else nand_io_o_r <= fifo_data;
      end
   end

   // user answers
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cmd_ready <= 1'b1;
         done_r <= 1'b0;
         err_r <= 1'b0;
         busy_r <= 1'b0;
         status_r <= 8'h00;
      end else if (en) begin
         cmd_ready <= (!run && !(take && !refused)) ||
                      (run && elem.kind == nmpe_pkg::EK_END);
         done_r <= run && elem.kind == nmpe_pkg::EK_END;
         err_r <= take && refused;
         busy_r <= run;
         if (run && elem.kind == nmpe_pkg::EK_READ && cnt_r == RE_LO)
            status_r <= io_s2_r;
      end
   end

   // program count per page
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         last_pg_r <= 17'h00000;
         nprog_r <= 3'h0;
      end else if (en && take && !refused) begin
         if (is_prog || cmd_op == nmpe_pkg::OP_COPY) begin
            if (key == last_pg_r) nprog_r <= nprog_r + 3'h1;
            else nprog_r <= 3'h1;
            last_pg_r <= key;
         end else if ((cmd_op == nmpe_pkg::OP_ERASE ||
                       cmd_op == nmpe_pkg::OP_MERASE) &&
                      (last_pg_r[16:6] == cmd_block1 ||
                       (cmd_op == nmpe_pkg::OP_MERASE &&
                        last_pg_r[16:6] == cmd_block2))) begin
            nprog_r <= 3'h0;
         end
      end
   end

   // helpers that watch the strobes
   logic we_q_r, cmd_rise, addr_rise;
   logic [7:0] prev_cmd_r;
   logic [2:0] acnt_r;
   assign cmd_rise = nand_cle_r && nand_we_n_r && !we_q_r;
   assign addr_rise = nand_ale_r && nand_we_n_r && !we_q_r;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         we_q_r <= 1'b1;
         prev_cmd_r <= `NMPE_CMD_RESET;
         acnt_r <= 3'h0;
      end else if (en) begin
         we_q_r <= nand_we_n_r;
         if (cmd_rise) prev_cmd_r <= nand_io_o_r;
         if (cmd_rise) acnt_r <= 3'h0;
         else if (addr_rise) acnt_r <= acnt_r + 3'h1;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   latch_levels_a: assert property (
      nand_cle_r |-> !nand_ale_r && !nand_ce_n_r)
      else $error("command latch with address latch or deselect");
   wp_held_a: assert property (busy_r |-> nand_wp_n_r)
      else $error("write protect low during operation");
   second_page_a: assert property (
      cmd_rise && nand_io_o_r == `NMPE_CMD_SECOND_PAGE |->
      prev_cmd_r == `NMPE_CMD_PAGE_END)
      else $error("second page not right after page end");
   confirm_seq_a: assert property (
      cmd_rise && nand_io_o_r == `NMPE_CMD_PROG_CONFIRM |->
      prev_cmd_r inside {`NMPE_CMD_SERIAL_IN, `NMPE_CMD_SECOND_PAGE,
                         `NMPE_CMD_COL_CHANGE})
      else $error("confirm without data input command");
   erase_start_a: assert property (
      cmd_rise && nand_io_o_r == `NMPE_CMD_ERASE_START |->
      prev_cmd_r == `NMPE_CMD_ERASE_SETUP && acnt_r == 3'h3)
      else $error("erase start not after setup and row");
   addr_count_a: assert property (
      cmd_rise |-> acnt_r inside {3'h0, 3'h3, 3'h5})
      else $error("bad address byte count");
   district_split_a: assert property (
      take && is_multi && cmd_block1[0] == cmd_block2[0] |=>
      err_r && !busy_r)
      else $error("same district multi op not refused");
   copy_district_a: assert property (
      take && cmd_op == nmpe_pkg::OP_COPY &&
      cmd_block1[0] != cmd_block2[0] |=> err_r ##1 !busy_r)
      else $error("cross district copy not refused");
   short_prog_a: assert property (
      take && is_prog && cmd_len < `NMPE_SECTOR_BYTES |=> err_r)
      else $error("short program not refused");
   abort_reset_a: assert property (
      en && abort_go |-> ##[1:12] cmd_rise &&
      nand_io_o_r == `NMPE_CMD_RESET)
      else $error("abort did not issue reset command");

   mprog_done_c: cover property (done_r && op_r == nmpe_pkg::OP_MPROG);
   merase_done_c: cover property (done_r && op_r == nmpe_pkg::OP_MERASE);
   copy_done_c: cover property (done_r && op_r == nmpe_pkg::OP_COPY);
   abort_c: cover property (abort_go);
endmodule : nmpe_host

// *** tb/nmpe_dev.sv ***
module nmpe_dev #(
   parameter int BUSY = 40
) (
   input wire logic clk,
   input wire logic ce_n,
   input wire logic cle,
   input wire logic ale,
   input wire logic we_n,
   input wire logic re_n,
   input wire logic wp_n,
   input wire logic [7:0] io_o,
   input wire logic oe,
   input wire logic [1:0] inj,
   output logic [7:0] io_i,
   output logic rb
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] cmd_r = 8'hff;
   logic [7:0] last_r = 8'h00;
   logic [7:0] st;
   logic [2:0] acnt_r = 3'h0;
   logic [1:0] used_r = 2'h0;
   logic [1:0] fail_r = 2'h0;
   logic go_r = 1'b0;
   logic gos_r = 1'b0;
   logic [7:0] bcnt_r = 8'h00;
   // latch command and address bytes on the write strobe
   always @(posedge we_n) begin
      if (!ce_n && cle && !ale && (rb || io_o inside {8'h70, 8'h71, 8'hff}))
      begin
         cmd_r <= io_o;
         acnt_r <= 3'h0;
         if (io_o inside {8'h10, 8'hd0}) begin
            fail_r <= (used_r & inj) | {2{!wp_n}};
            used_r <= 2'h0;
         end
         if (io_o inside {8'h10, 8'hd0, 8'h11, 8'h35, 8'hff}) begin
            go_r <= ~go_r;
         end
         if (io_o == 8'hff) begin
            fail_r <= 2'h0;
         end
      end else if (!ce_n && ale && rb) begin
         acnt_r <= acnt_r + 3'h1;
         if (acnt_r == ((cmd_r == 8'h60) ? 3'h0 : 3'h2)) begin
            used_r[io_o[6]] <= 1'b1;
         end
      end
   end
   // busy span after each start command
   always @(posedge clk) begin
      gos_r <= go_r;
      last_r <= io_i;
      if (go_r != gos_r) begin
         bcnt_r <= 8'(BUSY);
      end else if (bcnt_r != 8'h00) begin
         bcnt_r <= bcnt_r - 8'h01;
      end
   end
   assign rb = (bcnt_r == 8'h00);
   // status byte, held until the next command
   assign st = (cmd_r == 8'h71) ?
      {wp_n, rb, rb, 2'h0, fail_r, |fail_r} : {wp_n, rb, rb, 4'h0, |fail_r};
   // undriven bus shows a changing pattern
   assign io_i = oe ? io_o : (!ce_n && !re_n) ? st : ~last_r;
endmodule : nmpe_dev

// *** tb/nmpe_host_tb.sv ***
module nmpe_host_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, rst_b = 1'b0, cmd_valid = 1'b0, abort = 1'b0;
   logic wp_req = 1'b0, wr_valid = 1'b1;
   logic [7:0] wr_data = 8'h00;
   nmpe_pkg::nmpe_op_t cmd_op = nmpe_pkg::OP_STATUS;
   logic [10:0] b1 = 11'h000, b2 = 11'h000;
   logic [5:0] pg = 6'h03;
   logic [11:0] len = 12'h000;
   logic [1:0] inj = 2'h0;
   logic cmd_ready, wr_ready, done_r, err_r, busy_r, ce_n, cle, ale;
   logic we_n, re_n, wp_n, oe, rb;
   logic [7:0] status_r, io_o, io_i;
   int err_total = 0;
   int n_tests = 0;
   always #5 clk = ~clk;
   // endless byte stream into the fifo
   always @(negedge clk) if (wr_ready) wr_data <= wr_data + 8'h01;
   nmpe_host u_nmpe_host (.clk(clk), .rst_b(rst_b), .en(1'b1),
      .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
      .cmd_block1(b1), .cmd_block2(b2), .cmd_page(pg), .cmd_col(12'h000),
      .cmd_len(len), .abort(abort), .wp_req(wp_req), .wr_valid(wr_valid),
      .wr_ready(wr_ready), .wr_data(wr_data), .done_r(done_r),
      .err_r(err_r), .busy_r(busy_r), .status_r(status_r),
      .nand_ce_n_r(ce_n), .nand_cle_r(cle), .nand_ale_r(ale),
      .nand_we_n_r(we_n), .nand_re_n_r(re_n), .nand_wp_n_r(wp_n),
      .nand_io_o_r(io_o), .nand_io_oe_r(oe), .nand_io_i(io_i),
      .ready_busy_n(rb));
   nmpe_dev u_nmpe_dev (.clk(clk), .ce_n(ce_n), .cle(cle), .ale(ale),
      .we_n(we_n), .re_n(re_n), .wp_n(wp_n), .io_o(io_o), .oe(oe),
      .inj(inj), .io_i(io_i), .rb(rb));
   task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_tests++;
      if (g !== e) begin
         err_total++;
         $display("mismatch %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   task summarize;
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : summarize
   // one request, released after its taking edge
   task run(input nmpe_pkg::nmpe_op_t op, input logic [10:0] x, y,
            input logic [11:0] l);
      @(negedge clk);
      cmd_op = op; b1 = x; b2 = y; len = l; cmd_valid = 1'b1;
      @(negedge clk);
      cmd_valid = 1'b0;
   endtask : run
   task fin(input logic [7:0] e, input bit st);
      int i;
      chk("ready", 8'h00, {7'h0, cmd_ready});
      for (i = 0; i < 20000 && done_r !== 1'b1; i++) @(negedge clk);
      chk("done", 8'h01, {7'h0, done_r});
      chk("ready", 8'h01, {7'h0, cmd_ready});
      if (st) chk("status", e, status_r);
   endtask : fin
   initial begin
      repeat (10) @(negedge clk);
      rst_b = 1'b1;
      run(nmpe_pkg::OP_PROG, 4, 0, 528); fin(8'he0, 1);
      repeat (3) begin
         run(nmpe_pkg::OP_PROG, 4, 0, 2112); fin(8'he0, 1);
      end
      run(nmpe_pkg::OP_PROG, 4, 0, 528); chk("err", 1, err_r);
      run(nmpe_pkg::OP_PROG, 6, 0, 527); chk("err", 1, err_r);
      run(nmpe_pkg::OP_MPROG, 2, 4, 528); chk("err", 1, err_r);
      run(nmpe_pkg::OP_COPY, 2, 3, 0); chk("err", 1, err_r);
      $display("program and refusal tests done");
      inj = 2'h2;
      run(nmpe_pkg::OP_MPROG, 2, 5, 528); fin(8'he5, 1);
      inj = 2'h1;
      run(nmpe_pkg::OP_ERASE, 6, 0, 0); fin(8'he1, 1);
      run(nmpe_pkg::OP_STATUS, 6, 0, 0); fin(8'he1, 1);
      inj = 2'h0;
      run(nmpe_pkg::OP_MERASE, 7, 2, 0); fin(8'he0, 1);
      run(nmpe_pkg::OP_COPY, 3, 5, 0); fin(8'he0, 1);
      $display("multi, erase and copy tests done");
      wp_req = 1'b1;
      repeat (3) @(negedge clk);
      chk("wp", 8'h00, {7'h0, wp_n});
      run(nmpe_pkg::OP_ERASE, 8, 0, 0);
      repeat (20) @(negedge clk);
      chk("wp", 8'h01, {7'h0, wp_n});
      abort = 1'b1;
      fin(8'h00, 0);
      abort = 1'b0;
      wp_req = 1'b0;
      $display("protect and abort tests done");
      summarize();
   end
   // watchdog: about twice the expected 40k cycles of the tests
   initial begin
      #800000;
      err_total++;
      summarize();
   end
endmodule : nmpe_host_tb
